// file: design/dflash_partition_command.sv
// Partition D-Flash command sequencer: validate, erase verify, program
module dflash_partition_command (
  input  wire logic                        i_mclk,
  input  wire logic                        i_resetn,
  input  wire logic                        i_command_complete_flag_clear,
  input  wire logic                        i_access_error_clear,
  input  wire dflash_part_pkg::cmd_params_t i_command_param_array,
  input  wire logic                        i_flash_ack,
  input  wire logic [15:0]                 i_flash_rdata,
  output logic                             o_command_complete_flag,
  output logic                             o_access_error_flag,
  output logic                             o_verify_fail,
  output logic                             o_busy,
  output dflash_part_pkg::flash_req_t      o_flash_req
);
  // Idle waits for launch; check judges counts; two verify passes; one program write
  typedef enum logic [2:0] {
    IDLE,
    CHECK,
    VERIFY_DF,
    VERIFY_NV,
    PROGRAM,
    DONE
  } state_t;

  state_t                        state;
  state_t                        next_state;
  dflash_part_pkg::cmd_params_t  params;
  dflash_part_pkg::cmd_params_t  next_params;
  logic [14:0]                   word;
  logic [14:0]                   next_word;
  logic                          command_complete_flag;
  logic                          next_command_complete_flag;
  logic                          access_error_flag;
  logic                          next_access_error_flag;
  logic                          vfail;
  logic                          next_vfail;
  dflash_part_pkg::flash_req_t   req;
  dflash_part_pkg::flash_req_t   next_req;
  logic                          counts_ok;
  logic [15:0]                   remain;
  logic [15:0]                   ratio_need;

  // Ratio test done as remain >= 8*emu, avoiding a divider
  always_comb begin
    remain     = {8'h00, dflash_part_pkg::DFLASH_SECTORS} - params.user_partition_sectors;
    ratio_need = {params.emu_buffer_sectors[12:0], 3'b000};
    counts_ok  = (params.cmd == dflash_part_pkg::CMD_PARTITION);
    if (params.user_partition_sectors > {8'h00, dflash_part_pkg::DFLASH_SECTORS}) begin
      counts_ok = 1'b0;
    end
    if (params.emu_buffer_sectors > {8'h00, dflash_part_pkg::BUF_RAM_SECTORS}) begin
      counts_ok = 1'b0;
    end
    if (params.emu_buffer_sectors != 16'h0000 && counts_ok) begin
      if (remain < {8'h00, dflash_part_pkg::MIN_EMU_SECTORS}) begin
        counts_ok = 1'b0;
      end
      if (remain < ratio_need) begin
        counts_ok = 1'b0;
      end
    end
  end

  always_comb begin
    next_state  = state;
    next_params = params;
    next_word   = word;
    next_command_complete_flag   = command_complete_flag;
    next_access_error_flag = access_error_flag;
    next_vfail  = vfail;
    next_req    = req;
    if (i_access_error_clear) begin
      next_access_error_flag = 1'b0;
    end
    case (state)
      IDLE: begin
        if (command_complete_flag && i_command_complete_flag_clear) begin
          next_params = i_command_param_array;
          next_command_complete_flag   = 1'b0;
          next_vfail  = 1'b0;
          next_state  = CHECK;
        end
      end
      CHECK: begin
        if (counts_ok) begin
          next_word  = 15'h0000;
          next_req   = '{rd: 1'b1, wr: 1'b0, addr: dflash_part_pkg::DFLASH_BASE,
                         wdata: 16'h0000};
          next_state = VERIFY_DF;
        end else begin
          next_access_error_flag = 1'b1;
          next_state  = DONE;
        end
      end
      VERIFY_DF, VERIFY_NV: begin
        if (i_flash_ack) begin
          next_req.rd = 1'b0;
          if (i_flash_rdata != dflash_part_pkg::ERASED_WORD) begin
            next_vfail = 1'b1;
            next_state = DONE;
          end else if (state == VERIFY_DF && word == dflash_part_pkg::DFLASH_LAST_WORD) begin
            next_word  = 15'h0000;
            next_req   = '{rd: 1'b1, wr: 1'b0, addr: dflash_part_pkg::NVINFO_ADDR,
                           wdata: 16'h0000};
            next_state = VERIFY_NV;
          end else if (state == VERIFY_NV && word == dflash_part_pkg::NVINFO_LAST_WORD) begin
            next_req   = '{rd: 1'b0, wr: 1'b1, addr: dflash_part_pkg::NVINFO_ADDR,
                           wdata: params.user_partition_sectors};
            next_state = PROGRAM;
          end else begin
            next_word     = word + 15'h0001;
            next_req.rd   = 1'b1;
            next_req.addr = req.addr + 23'h00_0002;
          end
        end
      end
      PROGRAM: begin
        if (i_flash_ack) begin
          next_req.wr = 1'b0;
          next_state  = DONE;
        end
      end
      DONE: begin
        next_command_complete_flag  = 1'b1;
        next_state = IDLE;
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state  <= IDLE;
      params <= '0;
      word   <= 15'h0000;
      command_complete_flag   <= 1'b1;
      access_error_flag <= 1'b0;
      vfail  <= 1'b0;
      req    <= '0;
    end else begin
      state  <= next_state;
      params <= next_params;
      word   <= next_word;
      command_complete_flag   <= next_command_complete_flag;
      access_error_flag <= next_access_error_flag;
      vfail  <= next_vfail;
      req    <= next_req;
    end
  end

  // Busy registered from the same next-state so it tracks the flag exactly
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (next_state != IDLE);
    end
  end

  assign o_command_complete_flag = command_complete_flag;
  assign o_access_error_flag     = access_error_flag;
  assign o_verify_fail           = vfail;
  assign o_flash_req             = req;
endmodule

// file: pkg/dflash_part_pkg.sv
// Constants and carrier types for the D-Flash partition command handler
package dflash_part_pkg;
  localparam logic [7:0]  CMD_PARTITION     = 8'h20;
  localparam logic [7:0]  DFLASH_SECTORS    = 8'h80;
  localparam logic [7:0]  BUF_RAM_SECTORS   = 8'h10;
  localparam logic [7:0]  MIN_EMU_SECTORS   = 8'h0C;
  localparam logic [7:0]  MIN_EMU_RATIO     = 8'h08;
  localparam logic [22:0] NVINFO_ADDR       = 23'h12_0000;
  localparam logic [22:0] DFLASH_BASE       = 23'h10_0000;
  localparam logic [14:0] DFLASH_LAST_WORD  = 15'h3FFF;
  localparam logic [14:0] NVINFO_LAST_WORD  = 15'h003F;
  localparam logic [15:0] ERASED_WORD       = 16'hFFFF;

  // Parameters captured at launch
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] user_partition_sectors;
    logic [15:0] emu_buffer_sectors;
  } cmd_params_t;

  // Word request to the flash array
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [22:0] addr;
    logic [15:0] wdata;
  } flash_req_t;
endpackage

// file: testbench/dflash_part_assertions.sv
// Assertions for the partition command sequencer
module dflash_part_chk (
  input wire logic                         i_mclk,
  input wire logic                         i_resetn,
  input wire logic                         i_command_complete_flag_clear,
  input wire logic                         i_access_error_clear,
  input wire dflash_part_pkg::cmd_params_t i_command_param_array,
  input wire logic                         i_flash_ack,
  input wire logic [15:0]                  i_flash_rdata,
  input wire logic                         o_command_complete_flag,
  input wire logic                         o_access_error_flag,
  input wire logic                         o_verify_fail,
  input wire logic                         o_busy,
  input wire dflash_part_pkg::flash_req_t  o_flash_req
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  wire logic [15:0] u = i_command_param_array.user_partition_sectors;
  wire logic [15:0] e = i_command_param_array.emu_buffer_sectors;
  wire logic [15:0] r = 16'h80 - u;
  wire logic go = i_command_complete_flag_clear && o_command_complete_flag;
  wire logic ok = i_command_param_array.cmd == 8'h20 && u <= 16'h80 && e <= 16'h10
    && (e == 16'h0 || (r >= 16'hC && r >= {e[12:0], 3'h0}));
  wire logic err = o_access_error_flag;
  logic [15:0] cap;
  always_ff @(posedge i_mclk) if (go) cap <= u;
  property p_go; go |=> !o_command_complete_flag && o_busy; endproperty
  a_go: assert property (p_go) else $error("launch not taken");
  property p_umax; go && u > 16'h80 |=> ##1 err; endproperty
  a_umax: assert property (p_umax) else $error("user count not refused");
  property p_emax; go && e > 16'h10 |=> ##1 err; endproperty
  a_emax: assert property (p_emax) else $error("buffer count not refused");
  property p_emin; go && e != 0 && u <= 16'h80 && r < 16'hC |=> ##1 err; endproperty
  a_emin: assert property (p_emin) else $error("small remainder not refused");
  property p_rat; go && e != 0 && e <= 16'h10 && r <= 16'h80 && r < {e[12:0], 3'h0} |=> ##1 err;
  endproperty
  a_rat: assert property (p_rat) else $error("low ratio not refused");
  property p_skip; go && !ok |=> (!o_flash_req.rd && !o_flash_req.wr) [*3]; endproperty
  a_skip: assert property (p_skip) else $error("refused command touched flash");
  property p_ver; go && ok |=> ##1 o_flash_req.rd && o_flash_req.addr == 23'h10_0000 && !err;
  endproperty
  a_ver: assert property (p_ver) else $error("verify did not start");
  property p_prog; o_flash_req.wr |-> o_flash_req.addr == 23'h12_0000 && o_flash_req.wdata == cap;
  endproperty
  a_prog: assert property (p_prog) else $error("bad program request");
  property p_done; go && !ok |=> ##2 o_command_complete_flag && !o_busy; endproperty
  a_done: assert property (p_done) else $error("refusal did not complete");
  c_ok: cover property (go && ok);
  c_bad: cover property (go && !ok);
  c_wr: cover property (o_flash_req.wr && i_flash_ack);
endmodule
bind dflash_partition_command dflash_part_chk u_chk (.i_mclk, .i_resetn, .i_command_complete_flag_clear,
  .i_access_error_clear, .i_command_param_array, .i_flash_ack, .i_flash_rdata,
  .o_command_complete_flag, .o_access_error_flag, .o_verify_fail, .o_busy, .o_flash_req);

// file: testbench/tb.sv
// Self-checking bench for the partition command sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 0, i_resetn = 0, i_command_complete_flag_clear = 0, i_access_error_clear = 0, i_flash_ack = 0;
  logic [15:0] i_flash_rdata = 16'hFFFF;
  dflash_part_pkg::cmd_params_t i_command_param_array = '0;
  logic o_command_complete_flag, o_access_error_flag, o_verify_fail, o_busy;
  dflash_part_pkg::flash_req_t o_flash_req;
  logic [22:0] bad = 23'h0;
  logic [15:0] wr_seen = 16'h0000;
  logic [39:0] cor [11] = '{40'h20_0080_0000, 40'h20_0081_0000, 40'h20_0074_0001,
    40'h20_0075_0001, 40'h20_0070_0002, 40'h20_0071_0002, 40'h20_0000_0010, 40'h20_0001_0010,
    40'h20_0000_0011, 40'h21_0000_0000, 40'h20_0000_0000};
  int seed = 19, n_mismatch = 0, n_tests = 0, k;
  always #4 i_mclk = ~i_mclk;
  dflash_partition_command DUT (.i_mclk, .i_resetn, .i_command_complete_flag_clear, .i_access_error_clear,
    .i_command_param_array, .i_flash_ack, .i_flash_rdata, .o_command_complete_flag,
    .o_access_error_flag, .o_verify_fail, .o_busy, .o_flash_req);
  // Array answers with occasional stalls; erased unless at the poisoned address
  // Back-to-back acks allowed so a full verify fits in the cycle budget
  always @(negedge i_mclk) begin
    i_flash_ack <= (o_flash_req.rd | o_flash_req.wr) & (2'($random(seed)) != 2'h0);
    i_flash_rdata <= (o_flash_req.addr == bad) ? 16'h0000 : 16'hFFFF;
  end
  always @(posedge i_mclk) begin
    if (o_flash_req.wr && i_flash_ack) wr_seen <= o_flash_req.wdata;
  end
  function automatic logic ok(input logic [39:0] p);
    logic [15:0] r;
    r = 16'h80 - p[31:16];
    return p[39:32] == 8'h20 && p[31:16] <= 16'h80 && p[15:0] <= 16'h10
      && (p[15:0] == 16'h0 || (r >= 16'hC && r >= {p[12:0], 3'h0}));
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(input logic [39:0] p);
    i_access_error_clear = 1'b1;
    @(negedge i_mclk);
    i_access_error_clear = 1'b0;
    i_command_param_array = p;
    i_command_complete_flag_clear = 1'b1;
    check(o_access_error_flag, 1'b0);
    @(negedge i_mclk);
    // Scrambled after launch: counts must have been latched already
    i_command_param_array = ~p;
    for (k = 0; k < 40000 && o_command_complete_flag !== 1'b1; k++) @(negedge i_mclk);
    i_command_complete_flag_clear = 1'b0;
    if (k == 40000) begin
      n_mismatch++;
      stop_test();
    end
    check(o_access_error_flag, !ok(p));
    check(o_verify_fail, ok(p) && bad != 0);
    check(o_busy, 1'b0);
    if (ok(p) && bad == 23'h0) check(wr_seen, p[31:16]);
    @(negedge i_mclk);
  endtask
  initial begin
    repeat (16) @(negedge i_mclk);
    i_resetn = 1'b1;
    bad = 23'h10_0000;
    foreach (cor[i]) run(cor[i]);
    repeat (40) run({8'h20, 8'h0, 8'($random(seed)), 11'h0, 5'($random(seed))});
    bad = 23'h12_0010;
    run(40'h20_0030_0004);
    bad = 23'h0;
    run(40'h20_0074_0001);
    stop_test();
  end
endmodule
